// [pkg/dcr_pkg.sv]
// Shared constants for the decompressor record output control block
package dcr_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CTRL_PRE = 8'h04;
  localparam logic [7:0] ADDR_CFG = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_LEN_LOW = 8'h18;
  localparam logic [7:0] ADDR_LEN_TOP = 8'h1C;
  localparam logic [7:0] ADDR_PATTERN = 8'h20;
  localparam logic [7:0] ADDR_PORT_CTL = 8'h24;
  localparam logic [7:0] ADDR_LEN_CNT = 8'h28;
  // Control fields
  localparam int CTRL_W = 5;
  localparam int C_EN = 0;
  localparam int C_PASS = 1;
  localparam int C_PREC = 2;
  localparam int C_PXFER = 3;
  localparam int C_BLANK = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  // Configuration fields
  localparam int G_VIDEO = 0;
  localparam int G_WIDE = 1;
  localparam logic [1:0] CFG_RST = 2'h2;
  // Interrupt status bits
  localparam int IRQ_W = 5;
  localparam int I_REC = 0;
  localparam int I_XFER = 1;
  localparam int I_LEN = 2;
  localparam int I_OVF = 3;
  localparam int I_UNF = 4;
  localparam logic [4:0] MASK_RST = 5'h1F;
  localparam logic [4:0] W1C_BITS = 5'h17;
  // Port control bits
  localparam int P_INRST = 0;
  localparam int P_OUTRST = 1;
  localparam logic [1:0] PORT_RST = 2'h0;
  // Record length
  localparam logic [23:0] LEN_LOW_RST = 24'hFF_FFFF;
  localparam logic [7:0] LEN_TOP_RST = 8'hFF;
  localparam logic [31:0] LEN_ONE = 32'h0000_0001;
  // Output byte queue and word packing
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [2:0] BPW_WIDE = 3'h4;
  localparam logic [2:0] BPW_NARROW = 3'h2;
endpackage : dcr_pkg

// [rtl/dcr_top.sv]
// Record-level output control around the decompression engine
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - After end-of-record in input, drop rest of that word; next word starts new record.
// - Count programmed length down; flag length error on early or missing end-of-record.
// - Zero-fill the last word port word per bus width; never pad video bytes.
// - Video byte moves on each edge where request and acknowledge are both low.
// - Video port drops padding and drives record-end strobe low on last byte.
// - Video transfer-end strobe low when end-of-record leaves and count is zero.
// - Video mode uses 16-byte output queue, no thresholds, no word port access.
// - When enabled, engine pulls input and decompresses or passes it unchanged.
// - Keep dictionary on enable toggle; clear it when pass-through changes.
// - Pause on record or transfer end stops input and clears enable.
// - Engine empty flag stays clear while any byte remains inside.
// - Control writes during a record are held and applied at record end.
// - Lower length bytes prearm; top byte write loads counter at once.
// - Five status bits, mask of one suppresses, low interrupt when any unmasked.
// - Post record done as end word leaves; transfer done when count hits zero.
// - Input overflow bit clears only by input queue reset.
// - Output underflow on empty read; cleared by writing one.
// - Blank bit emits pattern record then clears at its end.
// - Test pin high floats every output; low restores normal drive.
module dcr_top (
  input wire logic coreClk, // System clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  input wire logic [31:0] inWord, // Input queue head word
  input wire logic inWordValid, // Input queue not empty
  output logic inWordReady, // Input word taken
  input wire logic inQueueOverflow, // Input queue overflow pulse
  output logic inQueueReset, // Input queue reset level
  output logic [7:0] engInByte, // Byte to engine
  output logic engInValid, // Byte to engine valid
  input wire logic engInReady, // Engine takes byte
  input wire logic engEorSeen, // End mark decoded with taken byte
  input wire logic [7:0] engOutByte, // Decoded byte
  input wire logic engOutValid, // Decoded byte valid
  input wire logic engOutEor, // Decoded byte ends record
  output logic engOutReady, // Room for decoded byte
  input wire logic engIdle, // Engine holds no bytes
  output logic engDictClear, // Dictionary clear pulse
  output logic [31:0] outWord, // Word port data
  output logic outWordValid, // Word port data ready
  output logic outWordEor, // Word holds end of record
  input wire logic outWordStrobe, // Word port read strobe
  output logic [7:0] videoByteOut, // Video byte
  output logic videoByteRequestN, // Video byte valid, low
  input wire logic videoByteAckN, // Video acknowledge, low
  output logic videoRecordEndN, // Last byte of record, low
  output logic videoTransferEndN, // Last byte of transfer, low
  output logic irqOutN, // Interrupt, low
  input wire logic outputFloatPin, // Test float request
  output logic outputDriveEn // Drive enable for all output pins
);

  function automatic logic [2:0] bytesPerWord(input logic wide);
    bytesPerWord = wide ? dcr_pkg::BPW_WIDE : dcr_pkg::BPW_NARROW;
  endfunction : bytesPerWord

  logic [4:0] ctrl_r, ctrlPre_r, ctrl_nxt, ctrlPre_nxt;
  logic ctrlPend_r, ctrlPend_nxt;
  logic [1:0] cfg_r, portCtl_r;
  logic [7:0] pattern_r, lenTop_r;
  logic [23:0] lenLow_r;
  logic [31:0] lenCnt_r;
  logic [4:0] mask_r, irqStat_r;
  logic recBusy_r;
  logic wrPend_r;
  logic [7:0] wrAddr_r;
  logic [31:0] rdData;
  logic [31:0] uWord_r;
  logic [2:0] uLeft_r, uLeftAfter, uLeft_nxt;
  logic [7:0] fData_r [16];
  logic fLast_r [16];
  logic fXfer_r [16];
  logic [3:0] wp_r, rp_r;
  logic [4:0] fcnt_r, fcnt_nxt;
  logic [1:0] pkIdx_r;
  logic vidLast_r, vidXfer_r, outXfer_r;

  wire logic videoEn = cfg_r[dcr_pkg::G_VIDEO];
  wire logic [2:0] bpw = bytesPerWord(cfg_r[dcr_pkg::G_WIDE]);
  wire logic inRst = portCtl_r[dcr_pkg::P_INRST];
  wire logic outRst = portCtl_r[dcr_pkg::P_OUTRST];

  // Bus write decode, applied in the data phase
  wire logic wCtrl = wrPend_r && wrAddr_r == dcr_pkg::ADDR_CTRL;
  wire logic wCtrlPre = wrPend_r && wrAddr_r == dcr_pkg::ADDR_CTRL_PRE;
  wire logic wCfg = wrPend_r && wrAddr_r == dcr_pkg::ADDR_CFG;
  wire logic wStat = wrPend_r && wrAddr_r == dcr_pkg::ADDR_IRQ_STAT;
  wire logic wMask = wrPend_r && wrAddr_r == dcr_pkg::ADDR_IRQ_MASK;
  wire logic wLenLow = wrPend_r && wrAddr_r == dcr_pkg::ADDR_LEN_LOW;
  wire logic wLenTop = wrPend_r && wrAddr_r == dcr_pkg::ADDR_LEN_TOP;
  wire logic wPat = wrPend_r && wrAddr_r == dcr_pkg::ADDR_PATTERN;
  wire logic wPort = wrPend_r && wrAddr_r == dcr_pkg::ADDR_PORT_CTL;

  // Input side
  wire logic run = ctrl_r[dcr_pkg::C_EN] & ~ctrl_r[dcr_pkg::C_BLANK] & ~inRst;
  wire logic pass = ctrl_r[dcr_pkg::C_PASS];
  wire logic lenOne = lenCnt_r == dcr_pkg::LEN_ONE;
  wire logic fifoRoom = fcnt_r < dcr_pkg::FIFO_DEPTH & ~outRst;
  wire logic pTake = pass & run & (uLeft_r != 3'h0) & fifoRoom;
  wire logic dTake = engInValid & engInReady;
  wire logic consume = pTake | dTake;
  wire logic inLast = (dTake & engEorSeen) | (pTake & lenOne);
  wire logic load = inWordReady & inWordValid;

  // Output source selection
  wire logic blankOn = ctrl_r[dcr_pkg::C_BLANK] & ctrl_r[dcr_pkg::C_EN];
  wire logic dPush = engOutValid & engOutReady & ~outRst;
  wire logic push = blankOn ? fifoRoom : (pTake | dPush);
  wire logic [7:0] srcByte = blankOn ? pattern_r : (pTake ? uWord_r[7:0] : engOutByte);
  wire logic srcLast = (blankOn | pTake) ? lenOne : engOutEor;
  wire logic srcXfer = srcLast & lenOne;
  wire logic recEnd = push & srcLast;
  wire logic xferEnd = recEnd & lenOne;
  // Length mismatch: end mark with count left, or count expiring on a plain byte
  wire logic lenErr = dPush & (lenCnt_r != 32'h0000_0000) & (engOutEor != lenOne);

  // Drain side
  wire logic fNotEmpty = fcnt_r != 5'h00;
  wire logic vidFire = ~videoByteRequestN & ~videoByteAckN;
  wire logic vidLoad = videoEn & fNotEmpty & ~outRst & (videoByteRequestN | vidFire);
  wire logic packLoad = ~videoEn & fNotEmpty & ~outRst & ~outWordValid;
  wire logic pop = vidLoad | packLoad;
  wire logic strobeOk = outWordStrobe & outWordValid & ~videoEn;
  wire logic underflow = outWordStrobe & ~outWordValid & ~videoEn;
  wire logic packFull = fLast_r[rp_r] | ({1'b0, pkIdx_r} == bpw - 3'h1);

  wire logic engEmpty = engIdle & (uLeft_r == 3'h0) & ~fNotEmpty & videoByteRequestN
    & ~outWordValid & (pkIdx_r == 2'h0);

  // AHB-Lite slave: zero wait states, read data registered in the address phase
  always_ff @(posedge coreClk)
  begin
    if (srst)
    begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend_r <= hsel & htrans[1] & hready & hwrite;
      wrAddr_r <= haddr[7:0];
      if (hsel & htrans[1] & hready & ~hwrite)
        hrdata <= rdData;
    end
  end

  always_comb
  begin
    rdData = 32'h0000_0000;
    if (haddr[31:8] == 24'h00_0000)
    begin
      case (haddr[7:0])
        dcr_pkg::ADDR_CTRL: rdData[4:0] = ctrl_r;
        dcr_pkg::ADDR_CTRL_PRE: rdData[4:0] = ctrlPre_r;
        dcr_pkg::ADDR_CFG: rdData[1:0] = cfg_r;
        dcr_pkg::ADDR_STATUS: rdData[2:0] = {ctrlPend_r, recBusy_r, engEmpty};
        dcr_pkg::ADDR_IRQ_STAT: rdData[4:0] = irqStat_r;
        dcr_pkg::ADDR_IRQ_MASK: rdData[4:0] = mask_r;
        dcr_pkg::ADDR_LEN_LOW: rdData[23:0] = lenLow_r;
        dcr_pkg::ADDR_LEN_TOP: rdData[7:0] = lenTop_r;
        dcr_pkg::ADDR_PATTERN: rdData[7:0] = pattern_r;
        dcr_pkg::ADDR_PORT_CTL: rdData[1:0] = portCtl_r;
        dcr_pkg::ADDR_LEN_CNT: rdData = lenCnt_r;
        default: rdData = 32'h0000_0000;
      endcase
    end
  end

  // Control with prearm shadow
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    ctrlPre_nxt = ctrlPre_r;
    ctrlPend_nxt = ctrlPend_r;
    if (wCtrl & ~recBusy_r)
      ctrl_nxt = hwdata[dcr_pkg::CTRL_W-1:0];
    if ((wCtrl & recBusy_r) | wCtrlPre)
    begin
      ctrlPre_nxt = hwdata[dcr_pkg::CTRL_W-1:0];
      ctrlPend_nxt = 1'b1;
    end
    if (recEnd)
    begin
      if (ctrlPend_nxt)
      begin
        ctrl_nxt = ctrlPre_nxt;
        ctrlPend_nxt = 1'b0;
      end
      else
        ctrl_nxt[dcr_pkg::C_BLANK] = 1'b0;
    end
    // Pause wins over a prearmed enable so the host sees the stop
    if (inLast & ctrl_r[dcr_pkg::C_PREC])
      ctrl_nxt[dcr_pkg::C_EN] = 1'b0;
    if (xferEnd & ctrl_r[dcr_pkg::C_PXFER])
      ctrl_nxt[dcr_pkg::C_EN] = 1'b0;
  end

  always_ff @(posedge coreClk)
  begin
    if (srst)
    begin
      ctrl_r <= dcr_pkg::CTRL_RST;
      ctrlPre_r <= dcr_pkg::CTRL_RST;
      ctrlPend_r <= 1'b0;
      engDictClear <= 1'b0;
      recBusy_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      ctrlPre_r <= ctrlPre_nxt;
      ctrlPend_r <= ctrlPend_nxt;
      // Enable toggles leave the dictionary alone
      engDictClear <= ctrl_nxt[dcr_pkg::C_PASS] != ctrl_r[dcr_pkg::C_PASS];
      // The last byte must not re-arm busy, or later control writes stay shadowed
      recBusy_r <= (recBusy_r & ~recEnd) | (consume & ~inLast) | (push & ~srcLast);
    end
  end

  // Plain configuration registers
  always_ff @(posedge coreClk)
  begin
    if (srst)
    begin
      cfg_r <= dcr_pkg::CFG_RST;
      pattern_r <= 8'h00;
      mask_r <= dcr_pkg::MASK_RST;
      portCtl_r <= dcr_pkg::PORT_RST;
    end
    else
    begin
      if (wCfg)
        cfg_r <= hwdata[1:0];
      if (wPat)
        pattern_r <= hwdata[7:0];
      if (wMask)
        mask_r <= hwdata[dcr_pkg::IRQ_W-1:0];
      if (wPort)
        portCtl_r <= hwdata[1:0];
    end
  end

  // Record length: low bytes held for the next reload, top byte loads at once
  always_ff @(posedge coreClk)
  begin
    if (srst)
    begin
      lenLow_r <= dcr_pkg::LEN_LOW_RST;
      lenTop_r <= dcr_pkg::LEN_TOP_RST;
      lenCnt_r <= {dcr_pkg::LEN_TOP_RST, dcr_pkg::LEN_LOW_RST};
    end
    else
    begin
      if (wLenLow)
        lenLow_r <= hwdata[23:0];
      if (wLenTop)
        lenTop_r <= hwdata[7:0];
      if (wLenTop)
        lenCnt_r <= {hwdata[7:0], lenLow_r};
      else if (recEnd)
        lenCnt_r <= {lenTop_r, lenLow_r};
      else if (push & (lenCnt_r != 32'h0000_0000))
        lenCnt_r <= lenCnt_r - dcr_pkg::LEN_ONE;
    end
  end

  // Input word unpacker
  always_comb
  begin
    uLeftAfter = uLeft_r;
    if (consume)
      uLeftAfter = inLast ? 3'h0 : uLeft_r - 3'h1;
    uLeft_nxt = load ? bpw : uLeftAfter;
  end

  always_ff @(posedge coreClk)
  begin
    if (srst | inRst)
    begin
      uWord_r <= 32'h0000_0000;
      uLeft_r <= 3'h0;
      inWordReady <= 1'b0;
      engInValid <= 1'b0;
    end
    else
    begin
      if (load)
        uWord_r <= inWord;
      else if (consume)
        uWord_r <= {8'h00, uWord_r[31:8]};
      uLeft_r <= uLeft_nxt;
      inWordReady <= (uLeft_nxt == 3'h0) & ctrl_nxt[dcr_pkg::C_EN] & ~ctrl_nxt[dcr_pkg::C_BLANK];
      engInValid <= (uLeft_nxt != 3'h0) & ctrl_nxt[dcr_pkg::C_EN]
        & ~ctrl_nxt[dcr_pkg::C_PASS] & ~ctrl_nxt[dcr_pkg::C_BLANK];
    end
  end

  assign engInByte = uWord_r[7:0];
  assign inQueueReset = portCtl_r[dcr_pkg::P_INRST];

  // Output byte queue, 16 entries, each with record and transfer end marks
  always_comb
  begin
    fcnt_nxt = fcnt_r + {4'h0, push} - {4'h0, pop};
    if (outRst)
      fcnt_nxt = 5'h00;
  end

  always_ff @(posedge coreClk)
  begin
    if (srst | outRst)
    begin
      wp_r <= 4'h0;
      rp_r <= 4'h0;
      fcnt_r <= 5'h00;
      engOutReady <= 1'b0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 4'h1;
      if (pop)
        rp_r <= rp_r + 4'h1;
      fcnt_r <= fcnt_nxt;
      engOutReady <= (fcnt_nxt < dcr_pkg::FIFO_DEPTH) & ~ctrl_nxt[dcr_pkg::C_PASS]
        & ~ctrl_nxt[dcr_pkg::C_BLANK];
    end
  end

  always_ff @(posedge coreClk)
  begin
    if (push)
    begin
      fData_r[wp_r] <= srcByte;
      fLast_r[wp_r] <= srcLast;
      fXfer_r[wp_r] <= srcXfer;
    end
  end

  // Video port: only real bytes enter the queue, so no padding can appear
  always_ff @(posedge coreClk)
  begin
    if (srst | outRst | ~videoEn)
    begin
      videoByteRequestN <= 1'b1;
      videoByteOut <= 8'h00;
      vidLast_r <= 1'b0;
      vidXfer_r <= 1'b0;
      videoRecordEndN <= 1'b1;
      videoTransferEndN <= 1'b1;
    end
    else if (vidLoad)
    begin
      videoByteRequestN <= 1'b0;
      videoByteOut <= fData_r[rp_r];
      vidLast_r <= fLast_r[rp_r];
      vidXfer_r <= fXfer_r[rp_r];
      videoRecordEndN <= ~fLast_r[rp_r];
      videoTransferEndN <= ~fXfer_r[rp_r];
    end
    else if (vidFire)
    begin
      videoByteRequestN <= 1'b1;
      vidLast_r <= 1'b0;
      vidXfer_r <= 1'b0;
      videoRecordEndN <= 1'b1;
      videoTransferEndN <= 1'b1;
    end
  end

  // Word packer: a fresh word starts at zero, so a short last word is zero padded
  always_ff @(posedge coreClk)
  begin
    if (srst | outRst)
    begin
      outWord <= 32'h0000_0000;
      outWordValid <= 1'b0;
      outWordEor <= 1'b0;
      outXfer_r <= 1'b0;
      pkIdx_r <= 2'h0;
    end
    else if (packLoad)
    begin
      outWord <= ((pkIdx_r == 2'h0) ? 32'h0000_0000 : outWord)
        | ({24'h00_0000, fData_r[rp_r]} << {pkIdx_r, 3'b000});
      if (packFull)
      begin
        outWordValid <= 1'b1;
        outWordEor <= fLast_r[rp_r];
        outXfer_r <= fXfer_r[rp_r];
        pkIdx_r <= 2'h0;
      end
      else
        pkIdx_r <= pkIdx_r + 2'h1;
    end
    else if (strobeOk)
    begin
      outWordValid <= 1'b0;
      outWordEor <= 1'b0;
      outXfer_r <= 1'b0;
    end
  end

  // Interrupt status: a new event in the clearing cycle is kept
  logic [4:0] irqSet, irqClr;
  always_comb
  begin
    irqSet = 5'h00;
    irqSet[dcr_pkg::I_REC] = (strobeOk & outWordEor) | (vidFire & vidLast_r);
    irqSet[dcr_pkg::I_XFER] = (strobeOk & outXfer_r) | (vidFire & vidXfer_r);
    irqSet[dcr_pkg::I_LEN] = lenErr;
    irqSet[dcr_pkg::I_OVF] = inQueueOverflow;
    irqSet[dcr_pkg::I_UNF] = underflow;
    irqClr = wStat ? (hwdata[4:0] & dcr_pkg::W1C_BITS) : 5'h00;
    irqClr[dcr_pkg::I_OVF] = inRst;
  end

  always_ff @(posedge coreClk)
  begin
    if (srst)
    begin
      irqStat_r <= 5'h00;
      irqOutN <= 1'b1;
      outputDriveEn <= 1'b0;
    end
    else
    begin
      irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
      irqOutN <= ~|(irqStat_r & ~mask_r);
      outputDriveEn <= ~outputFloatPin;
    end
  end

endmodule : dcr_top

// [test/dcr_far_model.sv]
// Far-side model: pass-through engine and stalling video consumer
`timescale 1ns/1ps
module dcr_far_model (
  input wire logic coreClk, // Clock
  input wire logic srst, // Reset
  input wire logic [7:0] engInByte, // Byte in
  input wire logic engInValid, // Byte in valid
  output logic engInReady, // Byte accepted
  output logic engEorSeen, // End mark seen
  output logic [7:0] engOutByte, // Byte out
  output logic engOutValid, // Byte out valid
  output logic engOutEor, // Byte ends record
  input wire logic engOutReady, // Room downstream
  output logic engIdle, // Nothing held
  input wire logic [7:0] videoByteOut, // Video byte
  input wire logic videoByteRequestN, // Video request
  output logic videoByteAckN, // Video ack
  input wire logic videoRecordEndN, // Record end
  input wire logic videoTransferEndN // Transfer end
);
  logic held;
  logic [9:0] got[$];
  assign engInReady = !held;
  assign engOutValid = held;
  assign engIdle = !held;
  // Pass-through data carries no end marks
  assign engEorSeen = 1'h0;
  assign engOutEor = 1'h0;
  always_ff @(posedge coreClk)
  begin
    if (srst)
      held <= 1'h0;
    else if (engInValid && engInReady)
    begin
      held <= 1'h1;
      engOutByte <= engInByte;
    end
    else if (engOutValid && engOutReady)
    begin
      held <= 1'h0;
      // Stale value inverted so a late read cannot pass
      engOutByte <= ~engOutByte;
    end
  end
  // Ack every other cycle to exercise stalls
  always @(posedge coreClk)
  begin
    if (srst)
      videoByteAckN <= 1'h1;
    else
    begin
      videoByteAckN <= ~videoByteAckN;
      if (!videoByteRequestN && !videoByteAckN)
        got.push_back({~videoRecordEndN, ~videoTransferEndN, videoByteOut});
    end
  end
endmodule : dcr_far_model

// [test/dcr_top_props.sv]
// Port-level checker for the record output control block
`timescale 1ns/1ps
module dcr_top_props (
  input wire logic coreClk, // Clock
  input wire logic srst, // Reset
  input wire logic outputFloatPin, // Float request
  input wire logic outputDriveEn, // Drive enable
  input wire logic [7:0] videoByteOut, // Video byte
  input wire logic videoByteRequestN, // Video request
  input wire logic videoByteAckN, // Video ack
  input wire logic videoRecordEndN, // Record end
  input wire logic videoTransferEndN, // Transfer end
  input wire logic [31:0] outWord, // Word data
  input wire logic outWordValid, // Word valid
  input wire logic outWordEor, // Word end mark
  input wire logic outWordStrobe, // Word strobe
  input wire logic inWordValid, // Input valid
  input wire logic inWordReady, // Input taken
  input wire logic [7:0] engInByte, // Engine byte
  input wire logic engInValid, // Engine valid
  input wire logic engInReady, // Engine ready
  input wire logic engDictClear // Dictionary clear
);
  default clocking cb @(posedge coreClk);
  endclocking
  default disable iff (srst);
  sequence vidOffered;
    !videoByteRequestN && videoByteAckN;
  endsequence
  sequence vidHeld;
    !videoByteRequestN && $stable(videoByteOut) && $stable(videoRecordEndN);
  endsequence
  sequence floatLow;
    !outputFloatPin [*2];
  endsequence
  chk_float_drive: assert property (outputFloatPin |=> !outputDriveEn)
    else $error("outputs still driven while float requested");
  chk_drive_back: assert property (floatLow |=> outputDriveEn)
    else $error("outputs not driven after float released");
  chk_video_hold: assert property (vidOffered |=> vidHeld)
    else $error("video byte changed before acknowledge");
  chk_eot_eor: assert property (!videoTransferEndN |-> !videoRecordEndN)
    else $error("transfer end without record end");
  chk_word_hold: assert property (outWordValid && !outWordStrobe |=>
    outWordValid && $stable(outWord) && $stable(outWordEor))
    else $error("word port data lost before strobe");
  chk_in_take: assert property (inWordValid && inWordReady |=> !inWordReady)
    else $error("input ready stayed high after take");
  chk_eng_hold: assert property (engInValid && !engInReady |=>
    engInValid && $stable(engInByte))
    else $error("engine byte changed while stalled");
  chk_dict_pulse: assert property ($rose(engDictClear) |=> !engDictClear)
    else $error("dictionary clear longer than one cycle");
endmodule : dcr_top_props

// [test/dcr_top_tb_top.sv]
// Register-level testbench for the record output control block
`timescale 1ns/1ps
module dcr_top_tb_top;
  logic coreClk = 1'h0, srst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic inWordValid = 1'h0, inQueueOverflow = 1'h0, outWordStrobe = 1'h0;
  logic outputFloatPin = 1'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, inWord = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata, outWord, rd;
  logic [7:0] engInByte, engOutByte, videoByteOut;
  logic hreadyout, hresp, inWordReady, inQueueReset, engInValid, engInReady, engEorSeen;
  logic engOutValid, engOutEor, engOutReady, engIdle, engDictClear, outWordValid;
  logic outWordEor, videoByteRequestN, videoByteAckN, videoRecordEndN, videoTransferEndN;
  logic irqOutN, outputDriveEn;
  int errorCnt = 0, totalChecks = 0, cycles = 0;
  dcr_top u_dut (.coreClk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .inWord, .inWordValid, .inWordReady,
    .inQueueOverflow,
    .inQueueReset, .engInByte, .engInValid, .engInReady, .engEorSeen, .engOutByte,
    .engOutValid, .engOutEor, .engOutReady, .engIdle, .engDictClear, .outWord, .outWordValid,
    .outWordEor, .outWordStrobe, .videoByteOut, .videoByteRequestN, .videoByteAckN,
    .videoRecordEndN, .videoTransferEndN, .irqOutN, .outputFloatPin, .outputDriveEn);
  dcr_far_model u_far (.coreClk, .srst, .engInByte, .engInValid, .engInReady, .engEorSeen,
    .engOutByte, .engOutValid, .engOutEor, .engOutReady, .engIdle, .videoByteOut,
    .videoByteRequestN, .videoByteAckN, .videoRecordEndN, .videoTransferEndN);
  initial
  begin
    forever #4 coreClk = ~coreClk;
  end
  task wrapUp;
    $display("checks %0d mismatches %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrapUp
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge coreClk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errorCnt++;
      $display("[ERR] %0t run did not finish", $time);
      wrapUp;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task ticks(input int n);
    repeat (n) @(posedge coreClk);
  endtask : ticks
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge coreClk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    @(posedge coreClk);
    while (hreadyout !== 1'h1) @(posedge coreClk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge coreClk);
    while (hreadyout !== 1'h1) @(posedge coreClk);
    rd = hrdata;
  endtask : bus
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rchk
  task push(input logic [31:0] w);
    @(posedge coreClk);
    inWord <= w;
    inWordValid <= 1'h1;
    @(posedge coreClk);
    while (inWordReady !== 1'h1) @(posedge coreClk);
    inWordValid <= 1'h0;
  endtask : push
  task pop(input logic [31:0] exp, input logic expEor);
    @(posedge coreClk);
    while (outWordValid !== 1'h1) @(posedge coreClk);
    chk(outWord, exp);
    chk(32'(outWordEor), 32'(expEor));
    outWordStrobe <= 1'h1;
    @(posedge coreClk);
    outWordStrobe <= 1'h0;
  endtask : pop
  initial
  begin
    repeat (5) @(posedge coreClk);
    srst <= 1'h0;
    ticks(2);
    rchk(dcr_pkg::ADDR_CFG, 32'h0000_0002);
    rchk(dcr_pkg::ADDR_IRQ_MASK, 32'h0000_001F);
    rchk(dcr_pkg::ADDR_LEN_CNT, 32'hFFFF_FFFF);
    rchk(dcr_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    rchk(8'h3C, 32'h0000_0000);
    $display("test reset values done");
    bus(1'h1, dcr_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    @(posedge coreClk) inQueueOverflow <= 1'h1;
    @(posedge coreClk) inQueueOverflow <= 1'h0;
    ticks(3);
    rchk(dcr_pkg::ADDR_IRQ_STAT, 32'h0000_0008);
    chk(32'(irqOutN), 32'h0000_0000);
    bus(1'h1, dcr_pkg::ADDR_IRQ_STAT, 32'h0000_0008);
    rchk(dcr_pkg::ADDR_IRQ_STAT, 32'h0000_0008);
    bus(1'h1, dcr_pkg::ADDR_IRQ_MASK, 32'h0000_0008);
    ticks(3);
    chk(32'(irqOutN), 32'h0000_0001);
    rchk(dcr_pkg::ADDR_IRQ_STAT, 32'h0000_0008);
    bus(1'h1, dcr_pkg::ADDR_PORT_CTL, 32'h0000_0001);
    ticks(1);
    chk(32'(inQueueReset), 32'h0000_0001);
    bus(1'h1, dcr_pkg::ADDR_PORT_CTL, 32'h0000_0000);
    rchk(dcr_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    @(posedge coreClk) outWordStrobe <= 1'h1;
    @(posedge coreClk) outWordStrobe <= 1'h0;
    ticks(3);
    rchk(dcr_pkg::ADDR_IRQ_STAT, 32'h0000_0010);
    chk(32'(irqOutN), 32'h0000_0000);
    bus(1'h1, dcr_pkg::ADDR_IRQ_STAT, 32'h0000_0010);
    rchk(dcr_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    bus(1'h1, dcr_pkg::ADDR_PORT_CTL, 32'h0000_0002);
    bus(1'h1, dcr_pkg::ADDR_PORT_CTL, 32'h0000_0000);
    $display("test interrupts done");
    // Pass selected while idle, length set before any data
    bus(1'h1, dcr_pkg::ADDR_CTRL, 32'h0000_0002);
    bus(1'h1, dcr_pkg::ADDR_LEN_LOW, 32'h0000_0006);
    bus(1'h1, dcr_pkg::ADDR_LEN_TOP, 32'h0000_0000);
    rchk(dcr_pkg::ADDR_LEN_CNT, 32'h0000_0006);
    bus(1'h1, dcr_pkg::ADDR_CTRL, 32'h0000_0007);
    push(32'h4433_2211);
    push(32'hAABB_6655);
    pop(32'h4433_2211, 1'h0);
    pop(32'h0000_6655, 1'h1);
    ticks(4);
    rchk(dcr_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
    rchk(dcr_pkg::ADDR_CTRL, 32'h0000_0006);
    rchk(dcr_pkg::ADDR_LEN_CNT, 32'h0000_0006);
    bus(1'h1, dcr_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
    $display("test word port record done");
    // Next record held off until reprogramming is complete
    bus(1'h1, dcr_pkg::ADDR_CFG, 32'h0000_0003);
    bus(1'h1, dcr_pkg::ADDR_LEN_LOW, 32'h0000_0005);
    bus(1'h1, dcr_pkg::ADDR_LEN_TOP, 32'h0000_0000);
    bus(1'h1, dcr_pkg::ADDR_CTRL, 32'h0000_0003);
    push(32'h1413_1211);
    push(32'hDDCC_BB15);
    while (u_far.got.size() < 5) @(posedge coreClk);
    ticks(8);
    chk(32'(u_far.got.size()), 32'h0000_0005);
    for (int i = 0; i < 5; i++)
      chk(32'(u_far.got[i]), 32'({(i == 4) ? 2'h3 : 2'h0, 8'h11 + 8'(i)}));
    rchk(dcr_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
    $display("test video record done");
    bus(1'h1, dcr_pkg::ADDR_PATTERN, 32'h0000_005A);
    bus(1'h1, dcr_pkg::ADDR_CTRL, 32'h0000_0013);
    while (u_far.got.size() < 10) @(posedge coreClk);
    ticks(8);
    chk(32'(u_far.got.size()), 32'h0000_000A);
    chk(32'(u_far.got[5]), 32'h0000_005A);
    chk(32'(u_far.got[9]), 32'h0000_035A);
    rchk(dcr_pkg::ADDR_CTRL, 32'h0000_0003);
    $display("test blank record done");
    outputFloatPin <= 1'h1;
    ticks(2);
    chk(32'(outputDriveEn), 32'h0000_0000);
    outputFloatPin <= 1'h0;
    ticks(3);
    chk(32'(outputDriveEn), 32'h0000_0001);
    $display("test float done");
    wrapUp;
  end
endmodule : dcr_top_tb_top
bind dcr_top dcr_top_props u_props (.coreClk, .srst, .outputFloatPin, .outputDriveEn,
  .videoByteOut, .videoByteRequestN, .videoByteAckN, .videoRecordEndN, .videoTransferEndN,
  .outWord, .outWordValid, .outWordEor, .outWordStrobe, .inWordValid, .inWordReady,
  .engInByte, .engInValid, .engInReady, .engDictClear);
